// ==== ssc_board.sv ====
// board strap pulls and the phy manager's advertisement handshake
`timescale 1ns/100ps
module ssc_board (
  input wire logic ref_clk_i,
  input wire ssc_pkg::ssc_cfg_t pulls_i,
  input wire logic adv_req_i,
  output logic adv_ack_o,
  output ssc_pkg::ssc_cfg_t pins_o
);
  import ssc_pkg::*;
  logic [3:0] wait_r = 4'h0;
  assign pins_o = pulls_i;
  // a busy management engine answers a few cycles late, never at once
  always @(posedge ref_clk_i) begin
    wait_r <= adv_req_i ? wait_r + 4'h1 : 4'h0;
  end
  assign adv_ack_o = adv_req_i && wait_r == 4'h3;
endmodule

// ==== ssc_pause_hold.sv ====
// per-port hold-off of low priority flow control after a high priority frame
`timescale 1ns/100ps
module ssc_pause_hold (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic hit_i,
  output logic suspend_o
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic susp;
  } ssc_hold_st_t;

  ssc_hold_st_t r;
  ssc_hold_st_t r_nxt;

  always_comb begin
    r_nxt = r;
    if (!enable_i) begin
      r_nxt.cnt = 2'h0;
    end else if (hit_i) begin
      // a frame in the tick cycle restarts the hold rather than losing it
      r_nxt.cnt = HOLD_TICKS;
    end else if (tick_i && r.cnt != 2'h0) begin
      r_nxt.cnt = r.cnt - 2'h1;
    end
    r_nxt.susp = (r_nxt.cnt != 2'h0);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= r_nxt;
    end
  end

  assign suspend_o = r.susp;
endmodule

// ==== ssc_pkg.sv ====
// shared constants and types for the strap configuration block
package ssc_pkg;

  localparam int unsigned NUM_PORTS = 16;
  localparam int unsigned NUM_TRUNKS = 4;
  localparam int unsigned TRUNK_SIZE = 4;
  localparam int unsigned CFG_W = 16;

  // clock and timing
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned HOLD_TICK_MS = 1000;
  localparam int unsigned HOLD_TICK_CYC = HOLD_TICK_MS * CYC_PER_MS;
  localparam int unsigned TIMER_W = 27;
  // two one-second ticks give a hold of one to two seconds
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  localparam logic [1:0] SETTLE_LAST = 2'h2;

  // register map (byte addresses)
  localparam int unsigned APB_AW = 12;
  localparam logic [APB_AW-1:0] REG_CONFIG = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_CONTROL = 12'h008;
  localparam int unsigned ST_FAULT_LSB = 0;
  localparam int unsigned ST_CAPTURED_BIT = 4;
  localparam int unsigned ST_ADV_DONE_BIT = 5;
  localparam int unsigned ST_SUSPEND_LSB = 16;
  localparam int unsigned CTL_LED_OFF_BIT = 0;

  // reserved group address range
  localparam logic [39:0] RSV_MAC_PREFIX = 40'h0180C20000;
  localparam logic [7:0] RSV_MAC_LO = 8'h03;
  localparam logic [7:0] RSV_MAC_HI = 8'h0F;

  // high priority codepoints
  localparam logic [5:0] DSCP_EF = 6'h2E;
  localparam logic [5:0] DSCP_AF1 = 6'h0A;
  localparam logic [5:0] DSCP_AF2 = 6'h12;
  localparam logic [5:0] DSCP_AF3 = 6'h1A;
  localparam logic [5:0] DSCP_AF4 = 6'h22;
  localparam logic [5:0] DSCP_NC_MASK = 6'h37;
  localparam logic [5:0] DSCP_NC_VAL = 6'h30;
  localparam logic [2:0] TAG_HIGH_MIN = 3'h4;

  // port priority codes
  localparam logic [1:0] PPRI_OFF = 2'h0;
  localparam logic [1:0] PPRI_2 = 2'h1;
  localparam logic [1:0] PPRI_4 = 2'h2;
  localparam logic [3:0] PPRI_2_LIMIT = 4'h2;
  localparam logic [3:0] PPRI_4_LIMIT = 4'h4;
  localparam logic [3:0] PPRI_8_LIMIT = 4'h8;

  typedef struct packed {
    logic rsv_drop;
    logic backpressure;
    logic fd_pause;
    logic [3:0] trunk_en;
    logic vlan_en;
    logic vlan_topo;
    logic [1:0] port_pri;
    logic tag_pri;
    logic ds_pri;
    logic [1:0] q_ratio;
    logic auto_off;
  } ssc_cfg_t;

  // values held until the straps are captured: the documented pull defaults
  localparam ssc_cfg_t CFG_DEFAULT = '{rsv_drop: 1'b0, backpressure: 1'b1, fd_pause: 1'b1,
    trunk_en: 4'h0, vlan_en: 1'b0, vlan_topo: 1'b0, port_pri: 2'h0, tag_pri: 1'b0,
    ds_pri: 1'b0, q_ratio: 2'h3, auto_off: 1'b0};

endpackage

// ==== ssc_strap_sva.sv ====
// assertions on the strap configuration block
`timescale 1ns/100ps
module ssc_strap_sva #(
  parameter int unsigned BLINK_CYC = 8
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic rx_valid_i,
  input wire logic [47:0] rx_dest_mac_i,
  input wire logic rx_class_valid_o,
  input wire logic rx_drop_o,
  input wire logic rx_flood_o,
  input wire logic phy_adv_req_o,
  input wire logic phy_adv_ack_i,
  input wire logic [ssc_pkg::NUM_TRUNKS-1:0] trunk_en_o,
  input wire logic vlan_en_o,
  input wire logic backpressure_en_o,
  input wire logic [1:0] queue_ratio_o,
  input wire logic [ssc_pkg::NUM_PORTS-1:0] link_up_i,
  input wire logic trunk_group0_led_n_o
);
  import ssc_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic rsv;
  logic fault;
  logic cap_r;
  logic adv_r;
  logic [31:0] run_r;
  assign rsv = rx_dest_mac_i[47:8] == 40'h0180C20000 && rx_dest_mac_i[7:0] >= 8'h03 && rx_dest_mac_i[7:0] <= 8'h0F;
  assign fault = trunk_en_o[0] && !(&link_up_i[3:0]);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cap_r <= 1'b0;
      adv_r <= 1'b0;
      run_r <= 32'h0;
    end else begin
      cap_r <= cap_r | phy_adv_req_o;
      adv_r <= adv_r | (phy_adv_req_o && phy_adv_ack_i);
      run_r <= (fault && !$changed(trunk_group0_led_n_o)) ? run_r + 32'h1 : 32'h0;
    end
  end
  rsv_hit_a: assert property (clk_en_i && rx_valid_i && rsv |=>
    rx_class_valid_o && rx_drop_o != rx_flood_o)
    else $error("reserved frame neither dropped nor flooded");
  rsv_miss_a: assert property (clk_en_i && rx_valid_i && !rsv |=> !rx_drop_o && !rx_flood_o)
    else $error("frame outside reserved range treated as reserved");
  vlan_trunk_a: assert property (|trunk_en_o |-> !vlan_en_o)
    else $error("vlan on while a trunk is enabled");
  led_dark_a: assert property (!trunk_en_o[0] [*2] |-> trunk_group0_led_n_o)
    else $error("disabled trunk led lit");
  blink_rate_a: assert property (run_r <= BLINK_CYC + 2)
    else $error("faulty trunk led not blinking");
  adv_drop_a: assert property (phy_adv_req_o && phy_adv_ack_i |=> !phy_adv_req_o)
    else $error("advertisement request held after ack");
  adv_once_a: assert property (adv_r |-> !phy_adv_req_o)
    else $error("advertisement requested twice");
  cfg_hold_a: assert property (cap_r |-> $stable(trunk_en_o) && $stable(vlan_en_o)
    && $stable(backpressure_en_o) && $stable(queue_ratio_o))
    else $error("captured setting changed");
  drop_c: cover property (rx_class_valid_o && rx_drop_o);
  blink_c: cover property (fault && $fell(trunk_group0_led_n_o));
  adv_c: cover property (phy_adv_req_o && phy_adv_ack_i);
endmodule
bind ssc_strap_top ssc_strap_sva #(.BLINK_CYC(BLINK_CYC)) u_sva (.ref_clk_i, .reset_i, .clk_en_i, .rx_valid_i,
  .rx_dest_mac_i, .rx_class_valid_o, .rx_drop_o, .rx_flood_o, .phy_adv_req_o, .phy_adv_ack_i, .trunk_en_o,
  .vlan_en_o, .backpressure_en_o, .queue_ratio_o, .link_up_i, .trunk_group0_led_n_o);

// ==== ssc_strap_top.sv ====
// strap capture, frame classification settings, flow control hold-off and trunk leds
//
// What this block does
// RULE_01 - drop strap 1 discards reserved group frames; 0 floods them
// RULE_02 - reserved range is 01-80-C2-00-00-03 through 01-80-C2-00-00-0F inclusive
// RULE_03 - backpressure strap 1 enables half-duplex backpressure, 0 disables; default 1
// RULE_04 - pause strap sets flow control and is advertised to phy register 4 once
// RULE_05 - each trunk strap groups four consecutive ports into one trunk
// RULE_06 - home vlan strap enables port vlan, forced off when any trunk enabled
// RULE_07 - topology strap 1 gives 15 vlans, 0 gives 14 vlans
// RULE_08 - port priority code 01/10/11 marks ports 0-1, 0-3, 0-7 high
// RULE_09 - tag priority strap 1 classifies by tag user priority
// RULE_10 - diffserv high codepoints: 101110, 001010, 010010, 011010, 100010, 11x000
// RULE_11 - other codepoints are low; strap 0 turns diffserv classification off
// RULE_12 - queue ratio code 11 strict, 10 8:1, 01 4:1, 00 2:1
// RULE_13 - auto-off suspends low queue flow control 1-2 s per high frame
// RULE_14 - flow control returns after a quiet 1-2 s period on that port
// RULE_15 - enabled trunk with all links up drives its led low
// RULE_16 - failed member link blinks the trunk led 250 ms on, 250 ms off
// RULE_17 - disabled trunk holds its led high and dark
// RULE_18 - settings captured at reset release and held until next reset
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
module ssc_strap_top #(
  parameter int unsigned BLINK_CYC = ssc_pkg::BLINK_HALF_CYC,
  parameter int unsigned TICK_CYC = ssc_pkg::HOLD_TICK_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic reserved_frame_drop_strap_i,
  input wire logic backpressure_strap_i,
  input wire logic fullduplex_pause_strap_i,
  input wire logic trunk_group0_strap_i,
  input wire logic trunk_group1_strap_i,
  input wire logic trunk_group2_strap_i,
  input wire logic trunk_group3_strap_i,
  input wire logic home_vlan_enable_strap_i,
  input wire logic vlan_topology_strap_i,
  input wire logic [1:0] port_priority_strap_i,
  input wire logic tag_priority_strap_i,
  input wire logic diffserv_priority_strap_i,
  input wire logic [1:0] queue_ratio_strap_i,
  input wire logic pause_auto_off_strap_i,
  input wire logic [ssc_pkg::NUM_PORTS-1:0] link_up_i,
  input wire logic rx_valid_i,
  input wire logic [3:0] rx_port_i,
  input wire logic [47:0] rx_dest_mac_i,
  input wire logic rx_tagged_i,
  input wire logic [2:0] rx_user_pri_i,
  input wire logic rx_ip_i,
  input wire logic [5:0] rx_dscp_i,
  input wire logic phy_adv_ack_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ssc_pkg::APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic rx_class_valid_o,
  output logic rx_drop_o,
  output logic rx_flood_o,
  output logic rx_high_pri_o,
  output logic [3:0] rx_class_port_o,
  output logic backpressure_en_o,
  output logic pause_en_o,
  output logic phy_adv_req_o,
  output logic phy_adv_pause_o,
  output logic [ssc_pkg::NUM_TRUNKS-1:0] trunk_en_o,
  output logic vlan_en_o,
  output logic vlan_topology_o,
  output logic [1:0] queue_ratio_o,
  output logic [ssc_pkg::NUM_PORTS-1:0] port_fc_en_o,
  output logic trunk_group0_led_n_o,
  output logic trunk_group1_led_n_o,
  output logic trunk_group2_led_n_o,
  output logic trunk_group3_led_n_o
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [1:0] settle;
    logic captured;
    ssc_cfg_t cfg;
    logic adv_req;
    logic adv_done;
    logic [TIMER_W-1:0] blink_cnt;
    logic blink_off;
    logic [TIMER_W-1:0] tick_cnt;
    logic tick;
    logic cls_valid;
    logic cls_drop;
    logic cls_flood;
    logic cls_high;
    logic [3:0] cls_port;
    logic [NUM_TRUNKS-1:0] led_n;
    logic led_off;
    logic [NUM_PORTS-1:0] fc_en;
    logic apb_ready;
    logic apb_err;
    logic [31:0] apb_rdata;
  } ssc_top_st_t;

  ssc_top_st_t r;
  ssc_top_st_t r_nxt;
  logic [CFG_W-1:0] strap_raw;
  logic [CFG_W-1:0] strap_sync;
  logic [NUM_PORTS-1:0] port_hit;
  logic [NUM_PORTS-1:0] port_susp;
  logic [NUM_TRUNKS-1:0] trunk_fault;

  function automatic logic is_reserved_mac(input logic [47:0] mac);
    is_reserved_mac = (mac[47:8] == RSV_MAC_PREFIX) && (mac[7:0] >= RSV_MAC_LO)
                      && (mac[7:0] <= RSV_MAC_HI); // [RULE_02]
  endfunction

  function automatic logic is_ds_high(input logic [5:0] ds);
    is_ds_high = (ds == DSCP_EF) || (ds == DSCP_AF1) || (ds == DSCP_AF2) || (ds == DSCP_AF3)
                 || (ds == DSCP_AF4) || ((ds & DSCP_NC_MASK) == DSCP_NC_VAL); // [RULE_10]
  endfunction

  function automatic logic port_is_high(input logic [1:0] code, input logic [3:0] port);
    case (code)
      PPRI_OFF: port_is_high = 1'b0;
      PPRI_2: port_is_high = (port < PPRI_2_LIMIT);
      PPRI_4: port_is_high = (port < PPRI_4_LIMIT);
      default: port_is_high = (port < PPRI_8_LIMIT);
    endcase
  endfunction

  // strap pins in the same bit order as the configuration record
  assign strap_raw = {reserved_frame_drop_strap_i, backpressure_strap_i, fullduplex_pause_strap_i,
                      trunk_group3_strap_i, trunk_group2_strap_i, trunk_group1_strap_i,
                      trunk_group0_strap_i, home_vlan_enable_strap_i, vlan_topology_strap_i,
                      port_priority_strap_i, tag_priority_strap_i, diffserv_priority_strap_i,
                      queue_ratio_strap_i, pause_auto_off_strap_i};

  ssc_sync2 u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i(strap_raw),
    .sync_o(strap_sync)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign port_hit[gp] = r.cls_valid && r.cls_high && (r.cls_port == 4'(gp));
      ssc_pause_hold u_hold (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .enable_i(r.cfg.auto_off),
        .tick_i(r.tick),
        .hit_i(port_hit[gp]),
        .suspend_o(port_susp[gp])
      ); // [RULE_13] [RULE_14]
    end
    for (gp = 0; gp < NUM_TRUNKS; gp++) begin : g_trunk
      assign trunk_fault[gp] = !(&link_up_i[gp*TRUNK_SIZE +: TRUNK_SIZE]); // [RULE_05]
    end
  endgenerate

  always_comb begin
    ssc_cfg_t cap;
    logic hi;
    logic rd_hit;
    cap = ssc_cfg_t'(strap_sync);
    hi = 1'b0;
    rd_hit = 1'b0;
    r_nxt = r;

    // capture once the synchroniser has filled after release, then freeze
    if (!r.captured) begin
      if (r.settle == SETTLE_LAST) begin
        r_nxt.captured = 1'b1;
        r_nxt.cfg = cap; // [RULE_18] [RULE_03] [RULE_07] [RULE_12]
        r_nxt.cfg.vlan_en = cap.vlan_en && (cap.trunk_en == 4'h0); // [RULE_06]
        r_nxt.adv_req = 1'b1;
      end else begin
        r_nxt.settle = r.settle + 2'h1;
      end
    end

    // single advertisement write, never repeated until the next reset
    if (r.adv_req && phy_adv_ack_i) begin
      r_nxt.adv_req = 1'b0;
      r_nxt.adv_done = 1'b1; // [RULE_04]
    end

    if (r.blink_cnt == TIMER_W'(BLINK_CYC - 1)) begin
      r_nxt.blink_cnt = '0;
      r_nxt.blink_off = !r.blink_off; // [RULE_16]
    end else begin
      r_nxt.blink_cnt = r.blink_cnt + TIMER_W'(1);
    end

    // shared tick; a per-port count of two ticks yields a one to two second hold
    r_nxt.tick = 1'b0;
    if (r.tick_cnt == TIMER_W'(TICK_CYC - 1)) begin
      r_nxt.tick_cnt = '0;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.tick_cnt = r.tick_cnt + TIMER_W'(1);
    end

    // classification result one cycle after the frame header
    if (r.cfg.port_pri != PPRI_OFF) begin
      hi = port_is_high(r.cfg.port_pri, rx_port_i); // [RULE_08]
    end
    if (r.cfg.tag_pri && rx_tagged_i && (rx_user_pri_i >= TAG_HIGH_MIN)) begin
      hi = 1'b1; // [RULE_09]
    end
    if (r.cfg.ds_pri && rx_ip_i && is_ds_high(rx_dscp_i)) begin
      hi = 1'b1; // [RULE_11]
    end
    r_nxt.cls_valid = rx_valid_i;
    r_nxt.cls_port = rx_port_i;
    r_nxt.cls_high = rx_valid_i && hi;
    r_nxt.cls_drop = rx_valid_i && is_reserved_mac(rx_dest_mac_i) && r.cfg.rsv_drop; // [RULE_01]
    r_nxt.cls_flood = rx_valid_i && is_reserved_mac(rx_dest_mac_i) && !r.cfg.rsv_drop; // [RULE_01]

    for (int p = 0; p < NUM_PORTS; p++) begin
      r_nxt.fc_en[p] = (r.cfg.fd_pause || r.cfg.backpressure) && !port_susp[p]; // [RULE_13]
    end

    for (int t = 0; t < NUM_TRUNKS; t++) begin
      if (!r.captured || !r.cfg.trunk_en[t] || r.led_off) begin
        r_nxt.led_n[t] = 1'b1; // [RULE_17]
      end else if (trunk_fault[t]) begin
        r_nxt.led_n[t] = r.blink_off; // [RULE_16]
      end else begin
        r_nxt.led_n[t] = 1'b0; // [RULE_15]
      end
    end

    // apb slave: one wait state, answer registered
    r_nxt.apb_ready = 1'b0;
    r_nxt.apb_err = 1'b0;
    if (psel_i && penable_i && !r.apb_ready) begin
      r_nxt.apb_ready = 1'b1;
      r_nxt.apb_rdata = '0;
      case (paddr_i)
        REG_CONFIG: begin
          r_nxt.apb_rdata[CFG_W-1:0] = r.cfg;
          rd_hit = 1'b1;
        end
        REG_STATUS: begin
          r_nxt.apb_rdata[ST_FAULT_LSB +: NUM_TRUNKS] = trunk_fault & r.cfg.trunk_en;
          r_nxt.apb_rdata[ST_CAPTURED_BIT] = r.captured;
          r_nxt.apb_rdata[ST_ADV_DONE_BIT] = r.adv_done;
          r_nxt.apb_rdata[ST_SUSPEND_LSB +: NUM_PORTS] = port_susp;
          rd_hit = 1'b1;
        end
        REG_CONTROL: begin
          r_nxt.apb_rdata[CTL_LED_OFF_BIT] = r.led_off;
          rd_hit = 1'b1;
        end
        default: rd_hit = 1'b0;
      endcase
      r_nxt.apb_err = !rd_hit;
    end
    if (psel_i && penable_i && r.apb_ready && pwrite_i && (paddr_i == REG_CONTROL)) begin
      r_nxt.led_off = pwdata_i[CTL_LED_OFF_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
      r.cfg <= CFG_DEFAULT;
      r.led_n <= '1;
    end else if (clk_en_i) begin
      r <= r_nxt;
    end
  end

  assign prdata_o = r.apb_rdata;
  assign pready_o = r.apb_ready;
  assign pslverr_o = r.apb_err;
  assign rx_class_valid_o = r.cls_valid;
  assign rx_drop_o = r.cls_drop;
  assign rx_flood_o = r.cls_flood;
  assign rx_high_pri_o = r.cls_high;
  assign rx_class_port_o = r.cls_port;
  assign backpressure_en_o = r.cfg.backpressure;
  assign pause_en_o = r.cfg.fd_pause;
  assign phy_adv_req_o = r.adv_req;
  assign phy_adv_pause_o = r.cfg.fd_pause;
  assign trunk_en_o = r.cfg.trunk_en;
  assign vlan_en_o = r.cfg.vlan_en;
  assign vlan_topology_o = r.cfg.vlan_topo;
  assign queue_ratio_o = r.cfg.q_ratio;
  assign port_fc_en_o = r.fc_en;
  assign trunk_group0_led_n_o = r.led_n[0];
  assign trunk_group1_led_n_o = r.led_n[1];
  assign trunk_group2_led_n_o = r.led_n[2];
  assign trunk_group3_led_n_o = r.led_n[3];
endmodule

// ==== ssc_sync2.sv ====
// two-stage synchroniser for the strap pins
`timescale 1ns/100ps
module ssc_sync2 (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [ssc_pkg::CFG_W-1:0] async_i,
  output logic [ssc_pkg::CFG_W-1:0] sync_o
);
  import ssc_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] s1;
    logic [CFG_W-1:0] s2;
  } ssc_sync_st_t;

  ssc_sync_st_t r;
  ssc_sync_st_t r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = async_i;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= r_nxt;
    end
  end

  assign sync_o = r.s2;
endmodule

// ==== tb_top.sv ====
// testbench for the strap configuration block
`timescale 1ns/100ps
module tb_top;
  import ssc_pkg::*;
  localparam int unsigned BLINK = 8;
  localparam int unsigned TICK = 16;
  localparam logic [47:0] MAC_U = 48'h001122334455;
  logic ref_clk_i, reset_i, rx_valid_i, rx_tagged_i, rx_ip_i, psel_i, penable_i, pwrite_i, clk_en_i;
  logic [3:0] rx_port_i, rx_class_port_o, trunk_en_o, led_n;
  logic [47:0] rx_dest_mac_i;
  logic [2:0] rx_user_pri_i;
  logic [5:0] rx_dscp_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [15:0] link_up_i, port_fc_en_o;
  logic [1:0] queue_ratio_o;
  logic pready_o, pslverr_o, rx_class_valid_o, rx_drop_o, rx_flood_o, rx_high_pri_o, backpressure_en_o;
  logic pause_en_o, phy_adv_req_o, phy_adv_pause_o, phy_adv_ack_i, vlan_en_o, vlan_topology_o;
  ssc_cfg_t pulls, pins;
  int errors, n_compared;
  ssc_board board (.ref_clk_i, .pulls_i(pulls), .adv_req_i(phy_adv_req_o), .adv_ack_o(phy_adv_ack_i), .pins_o(pins));
  ssc_strap_top #(.BLINK_CYC(BLINK), .TICK_CYC(TICK)) dut (.ref_clk_i, .reset_i, .clk_en_i,
    .reserved_frame_drop_strap_i(pins.rsv_drop), .backpressure_strap_i(pins.backpressure),
    .fullduplex_pause_strap_i(pins.fd_pause), .trunk_group0_strap_i(pins.trunk_en[0]),
    .trunk_group1_strap_i(pins.trunk_en[1]), .trunk_group2_strap_i(pins.trunk_en[2]),
    .trunk_group3_strap_i(pins.trunk_en[3]), .home_vlan_enable_strap_i(pins.vlan_en),
    .vlan_topology_strap_i(pins.vlan_topo), .port_priority_strap_i(pins.port_pri),
    .tag_priority_strap_i(pins.tag_pri), .diffserv_priority_strap_i(pins.ds_pri),
    .queue_ratio_strap_i(pins.q_ratio), .pause_auto_off_strap_i(pins.auto_off), .link_up_i, .rx_valid_i,
    .rx_port_i, .rx_dest_mac_i, .rx_tagged_i, .rx_user_pri_i, .rx_ip_i, .rx_dscp_i, .phy_adv_ack_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_class_valid_o,
    .rx_drop_o, .rx_flood_o, .rx_high_pri_o, .rx_class_port_o, .backpressure_en_o, .pause_en_o,
    .phy_adv_req_o, .phy_adv_pause_o, .trunk_en_o, .vlan_en_o, .vlan_topology_o, .queue_ratio_o,
    .port_fc_en_o, .trunk_group0_led_n_o(led_n[0]), .trunk_group1_led_n_o(led_n[1]),
    .trunk_group2_led_n_o(led_n[2]), .trunk_group3_led_n_o(led_n[3]));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd, output logic er);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk("pready", 1, 32'(pready_o));
    // one idle edge so a following call never reassigns psel in the same time step
    @(posedge ref_clk_i);
  endtask
  // straps must stay put from reset release until capture, so pulls change only here or after capture
  task automatic boot(ssc_cfg_t c);
    pulls <= c;
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask
  task automatic chk_cfg(ssc_cfg_t c);
    logic [31:0] rd;
    logic er;
    c.vlan_en = c.vlan_en & ~|c.trunk_en;
    apb(1'b0, REG_CONFIG, 32'h0, rd, er);
    chk("config", {16'h0, c}, rd);
    chk("trunks", 32'(c.trunk_en), 32'(trunk_en_o));
    chk("vlan", 32'({c.vlan_en, c.vlan_topo}), 32'({vlan_en_o, vlan_topology_o}));
    chk("bp", 32'(c.backpressure), 32'(backpressure_en_o));
    chk("pause", 32'({2{c.fd_pause}}), 32'({pause_en_o, phy_adv_pause_o}));
    chk("ratio", 32'(c.q_ratio), 32'(queue_ratio_o));
  endtask
  task automatic frame(logic [3:0] p, logic [47:0] m, logic tg, logic [2:0] up, logic ip, logic [5:0] ds,
                       logic [2:0] e);
    rx_valid_i <= 1'b1;
    rx_port_i <= p;
    rx_dest_mac_i <= m;
    rx_tagged_i <= tg;
    rx_user_pri_i <= up;
    rx_ip_i <= ip;
    rx_dscp_i <= ds;
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("class", 32'({1'b1, e, p}), 32'({rx_class_valid_o, rx_drop_o, rx_flood_o, rx_high_pri_o, rx_class_port_o}));
  endtask
  task automatic t_default();
    logic [31:0] rd;
    logic er;
    boot(CFG_DEFAULT);
    chk_cfg(CFG_DEFAULT);
    chk("leds", 32'hF, 32'(led_n));
    chk("fc_en", 32'hFFFF, 32'(port_fc_en_o));
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("adv_done", 32'h6, 32'({rd[5:4], phy_adv_req_o}));
    frame(4'h3, {RSV_MAC_PREFIX, 8'h05}, 1'b0, 3'h0, 1'b0, 6'h00, 3'b010);
    // a frame offered while the clock enable is low must leave no result
    clk_en_i <= 1'b0;
    rx_valid_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
    clk_en_i <= 1'b1;
    chk("frozen", 32'h0, 32'(rx_class_valid_o));
  endtask
  task automatic t_drop();
    ssc_cfg_t c;
    logic [7:0] lo [4] = '{8'h02, 8'h03, 8'h0F, 8'h10};
    c = CFG_DEFAULT;
    c.rsv_drop = 1'b1;
    c.backpressure = 1'b0;
    c.fd_pause = 1'b0;
    c.vlan_en = 1'b1;
    c.vlan_topo = 1'b1;
    boot(c);
    chk_cfg(c);
    chk("fc_en", 32'h0, 32'(port_fc_en_o));
    for (int i = 0; i < 4; i++) begin
      frame(4'h2, {RSV_MAC_PREFIX, lo[i]}, 0, 0, 0, 0, {lo[i] inside {[3:15]}, 2'b00});
    end
    frame(4'h2, 48'h0180C2000103, 1'b0, 3'h0, 1'b0, 6'h00, 3'b000);
    pulls <= ~c;
    repeat (6) @(posedge ref_clk_i);
    chk_cfg(c);
  endtask
  task automatic t_prio();
    ssc_cfg_t c;
    logic [3:0] lim [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
    logic [5:0] ds [11] = '{6'h2E, 6'h0A, 6'h12, 6'h1A, 6'h22, 6'h30, 6'h38, 6'h2C, 6'h3A, 6'h31, 6'h00};
    for (int k = 0; k < 4; k++) begin
      c = CFG_DEFAULT;
      c.port_pri = 2'(k);
      c.q_ratio = 2'(k);
      c.tag_pri = k[0];
      c.ds_pri = k[1];
      boot(c);
      chk_cfg(c);
      for (int p = 1; p < 16; p = p * 2) frame(4'(p), MAC_U, 0, 0, 0, 0, {2'b00, 4'(p) < lim[k]});
      frame(4'hF, MAC_U, 1'b1, 3'h4, 1'b0, 6'h00, {2'b00, k[0]});
      frame(4'hF, MAC_U, 1'b1, 3'h3, 1'b0, 6'h00, 3'b000);
      for (int i = 0; i < 11; i++) frame(4'hE, MAC_U, 0, 0, 1, ds[i], {2'b00, k[1] && i < 7});
    end
  endtask
  task automatic t_trunk();
    ssc_cfg_t c;
    logic [31:0] rd;
    logic er;
    logic prev;
    int n;
    c = CFG_DEFAULT;
    c.trunk_en = 4'h5;
    c.vlan_en = 1'b1;
    boot(c);
    chk_cfg(c);
    chk("leds", 32'hA, 32'(led_n));
    link_up_i[1] <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    n = 0;
    prev = led_n[0];
    repeat (6 * BLINK) begin
      @(posedge ref_clk_i);
      if (led_n[0] !== prev) n++;
      prev = led_n[0];
    end
    chk("blinks", 6, n);
    apb(1'b0, REG_STATUS, 32'h0, rd, er);
    chk("fault", 32'h1, 32'(rd[3:0]));
    link_up_i[1] <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("leds", 32'hA, 32'(led_n));
    apb(1'b1, REG_CONTROL, 32'h1, rd, er);
    repeat (2) @(posedge ref_clk_i);
    chk("led_off", 32'hF, 32'(led_n));
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("unmapped", 32'h1, {rd[30:0], er});
    apb(1'b1, REG_CONTROL, 32'h0, rd, er);
  endtask
  task automatic t_auto();
    ssc_cfg_t c;
    int n;
    c = CFG_DEFAULT;
    c.auto_off = 1'b1;
    c.port_pri = 2'h1;
    boot(c);
    chk_cfg(c);
    frame(4'h0, MAC_U, 1'b0, 3'h0, 1'b0, 6'h00, 3'b001);
    repeat (2) @(posedge ref_clk_i);
    chk("fc_off", 32'hFFFE, 32'(port_fc_en_o));
    n = 0;
    while (port_fc_en_o[0] !== 1'b1 && n < 3 * TICK) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("hold", 1, 32'(n >= TICK - 3 && n <= 2 * TICK + 3));
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100us;
    errors++;
    final_report();
  end
  initial begin
    {reset_i, rx_valid_i, rx_tagged_i, rx_ip_i, psel_i, penable_i, pwrite_i} = 7'h40;
    {rx_port_i, rx_dest_mac_i, rx_user_pri_i, rx_dscp_i, paddr_i, pwdata_i} = '0;
    link_up_i = 16'hFFFF;
    clk_en_i = 1'b1;
    pulls = CFG_DEFAULT;
    errors = 0;
    n_compared = 0;
    @(posedge ref_clk_i);
    t_default();
    t_drop();
    t_prio();
    t_trunk();
    t_auto();
    final_report();
  end
endmodule
